// [logic/amst_pkg.sv]
// shared constants and types of the asynchronous memory strobe sequencer
package amst_pkg;

    // =====================================================================
    // geometry
    localparam int unsigned SPACES      = 4;
    localparam int unsigned SPACE_W     = 2;
    localparam int unsigned ADDR_W      = 20;   // word address bits 21..2
    localparam int unsigned BE_W        = 4;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned CNT_W       = 6;
    localparam int unsigned MON_W       = 8;

    // =====================================================================
    // timing constants in cpu clock cycles
    localparam logic [CNT_W-1:0] CNT_ONE       = 6'h01;
    localparam logic [CNT_W-1:0] CNT_MAX       = 6'h3f;
    localparam logic [6:0]       EXT_MIN_SUM   = 7'h04;  // setup + strobe needed for ready stretch
    localparam logic [CNT_W-1:0] SAMPLE_OFFSET = 6'h03;  // ready sampled strobe - 3 cycles in
    localparam logic [MON_W-1:0] MON_MAX       = 8'hff;

    // =====================================================================
    // pll multiplier selection codes
    localparam logic [2:0] PLL_SEL_X4  = 3'h0;
    localparam logic [2:0] PLL_SEL_X6  = 3'h1;
    localparam logic [2:0] PLL_SEL_X7  = 3'h2;
    localparam logic [2:0] PLL_SEL_X8  = 3'h3;
    localparam logic [2:0] PLL_SEL_X9  = 3'h4;
    localparam logic [2:0] PLL_SEL_X10 = 3'h5;
    localparam logic [2:0] PLL_SEL_X11 = 3'h6;

    // =====================================================================
    // reset values
    localparam logic [SPACES-1:0] SEL_IDLE_N = 4'hf;
    localparam logic [BE_W-1:0]   BE_IDLE_N  = 4'hf;

    // per-space timing setting
    typedef struct packed {
        logic [3:0] read_setup_cycles;
        logic [5:0] read_strobe_cycles;
        logic [2:0] read_hold_cycles;
        logic [3:0] write_setup_cycles;
        logic [5:0] write_strobe_cycles;
        logic [2:0] write_hold_cycles;
    } amst_cfg_s;

    typedef amst_cfg_s [SPACES-1:0] amst_cfg_t;

    // one access request
    typedef struct packed {
        logic              write;
        logic [SPACE_W-1:0] space;
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0]   be;
        logic [DATA_W-1:0] wdata;
    } amst_req_s;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_SETUP  = 4'h2,
        ST_STROBE = 4'h4,
        ST_HOLD   = 4'h8
    } amst_state_e;

endpackage

// [logic/amst_ready_sync.sv]
// two-stage synchroniser for the asynchronous ready input
`timescale 1ns/1ps
module amst_ready_sync
(
    input  wire logic mclk_in,
    input  wire logic rst_b_in,
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_ff;

    // =====================================================================
    // synchroniser
    // first stage feeds only the second; resets high so an idle bus means no wait
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            meta_ff  <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule

// [logic/amst_async_seq.sv]
// asynchronous memory cycle sequencer with ready stretch and half-rate clock
// Contract
// R1 - select group stands read-setup cycles before the read strobe falls
// R2 - select group stays read-hold cycles after the read strobe rises
// R3 - without stretch the read strobe lasts exactly read-strobe cycles
// R4 - select group and write data stand write-setup cycles before write strobe
// R5 - select group and write data stay write-hold cycles after write strobe
// R6 - without stretch the write strobe lasts exactly write-strobe cycles
// R7 - ready input is synchronised internally and may arrive asynchronously
// R8 - read: ready sampled strobe minus three cycles in; low stretches strobe
// R9 - write: ready sampled strobe minus three cycles in; low stretches strobe
// R10 - read strobe ends three to four cycles after ready returns high
// R11 - write strobe ends three to four cycles after ready returns high
// R12 - external device keeps ready high at least two cycles once released
// R13 - ready stretch only when setup plus strobe count is at least four
// R14 - select group is chip select, byte enables, address, output enable, write data
// R15 - read and write setup, strobe, hold are set per chip-select space
// R16 - software picks strobe width to meet memory data setup
// R17 - cpu clock multiplier selectable among 4, 6, 7, 8, 9, 10, 11
// R18 - half-rate clock output is one cycle high, one cycle low
// R19 - below that sum the ready input is ignored and strobe runs its count
`timescale 1ns/1ps
module amst_async_seq
    import amst_pkg::*;
(
    input  wire logic               mclk_in,
    input  wire logic               rst_b_in,
    input  wire amst_cfg_t          space_cfg_in,
    input  wire logic [2:0]         pll_mode_sel_in,
    input  wire logic               req_valid_in,
    input  wire amst_req_s          req_in,
    input  wire logic               async_wait_release_in,
    input  wire logic [DATA_W-1:0]  ext_data_bus_in,
    output logic                    req_ready_out,
    output logic                    rsp_valid_out,
    output logic [DATA_W-1:0]       rsp_rdata_out,
    output logic [SPACES-1:0]       space_select_n_out,
    output logic [BE_W-1:0]         byte_lane_enable_n_out,
    output logic [ADDR_W-1:0]       ext_word_address_out,
    output logic                    async_output_enable_n_out,
    output logic                    async_read_strobe_n_out,
    output logic                    async_write_strobe_n_out,
    output logic [DATA_W-1:0]       ext_data_bus_out,
    output logic                    ext_data_bus_oe_out,
    output logic                    half_rate_clock_out,
    output logic [3:0]              pll_multiplier_out,
    output logic                    pll_mode_valid_out
);

    // =====================================================================
    // helpers
    // zero counts are run as one cycle so a phase never vanishes
    function automatic logic [CNT_W-1:0] len1(input logic [CNT_W-1:0] v);
        len1 = (v == 6'h00) ? CNT_ONE : v;
    endfunction

    function automatic logic [3:0] pll_decode(input logic [2:0] sel);
        unique case (sel)
            PLL_SEL_X4:  pll_decode = 4'h4;
            PLL_SEL_X6:  pll_decode = 4'h6;
            PLL_SEL_X7:  pll_decode = 4'h7;
            PLL_SEL_X8:  pll_decode = 4'h8;
            PLL_SEL_X9:  pll_decode = 4'h9;
            PLL_SEL_X10: pll_decode = 4'ha;
            PLL_SEL_X11: pll_decode = 4'hb;
            default:     pll_decode = 4'h0;
        endcase
    endfunction

    // =====================================================================
    // state and declarations
    amst_state_e        state_ff;
    amst_state_e        nxt_state;
    logic [CNT_W-1:0]   phase_cnt_ff;
    logic [CNT_W-1:0]   cur_setup_ff;
    logic [CNT_W-1:0]   cur_strobe_ff;
    logic [CNT_W-1:0]   cur_hold_ff;
    logic [CNT_W-1:0]   cur_samp_ff;
    logic               cur_ext_ok_ff;
    amst_req_s          cur_req_ff;
    logic               stretch_ff;
    logic               release_ff;
    logic               rdy_sync;
    logic               accept;
    logic               samp_hit;
    logic               active;
    amst_req_s          sel_req;
    amst_cfg_s          sel_cfg;
    logic [CNT_W-1:0]   sel_setup;
    logic [CNT_W-1:0]   sel_strobe;
    logic [CNT_W-1:0]   sel_hold;
    logic [6:0]         sel_sum;

    assign accept  = (state_ff == ST_IDLE) && req_valid_in && req_ready_out;
    assign sel_req = accept ? req_in : cur_req_ff;
    assign sel_cfg = space_cfg_in[req_in.space];

    // timing taken from the addressed space's own setting
    always_comb
    begin
        if (req_in.write)
        begin
            sel_setup  = len1({2'h0, sel_cfg.write_setup_cycles});  // R15
            sel_strobe = len1(sel_cfg.write_strobe_cycles);
            sel_hold   = len1({3'h0, sel_cfg.write_hold_cycles});
        end
        else
        begin
            sel_setup  = len1({2'h0, sel_cfg.read_setup_cycles});  // R15
            sel_strobe = len1(sel_cfg.read_strobe_cycles);
            sel_hold   = len1({3'h0, sel_cfg.read_hold_cycles});
        end
        sel_sum = {1'b0, sel_setup} + {1'b0, sel_strobe};
    end

    // =====================================================================
    // ready synchroniser
    amst_ready_sync u_ready_sync
    (
        .mclk_in  (mclk_in),
        .rst_b_in (rst_b_in),
        .async_in (async_wait_release_in),  // R7
        .sync_out (rdy_sync)
    );

    // =====================================================================
    // access latch: counts are frozen for the whole access
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            cur_req_ff    <= '0;
            cur_setup_ff  <= CNT_ONE;
            cur_strobe_ff <= CNT_ONE;
            cur_hold_ff   <= CNT_ONE;
            cur_samp_ff   <= CNT_ONE;
            cur_ext_ok_ff <= 1'b0;
        end
        else if (accept)
        begin
            cur_req_ff    <= req_in;
            cur_setup_ff  <= sel_setup;
            cur_strobe_ff <= sel_strobe;
            cur_hold_ff   <= sel_hold;
            cur_ext_ok_ff <= (sel_sum >= EXT_MIN_SUM);  // R13 R19
            // short strobes sample on their first cycle; the setup phase covers the rest
            cur_samp_ff   <= (sel_strobe > SAMPLE_OFFSET) ? (sel_strobe - SAMPLE_OFFSET) : CNT_ONE;
        end
    end

    // =====================================================================
    // phase sequencer
    assign samp_hit = (state_ff == ST_STROBE) && !stretch_ff && (phase_cnt_ff == cur_samp_ff);

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (accept)
                    nxt_state = ST_SETUP;
            end
            ST_SETUP:
            begin
                if (phase_cnt_ff == cur_setup_ff)
                    nxt_state = ST_STROBE;  // R1 R4
            end
            ST_STROBE:
            begin
                if (release_ff)
                    nxt_state = ST_HOLD;  // R10 R11
                else if (samp_hit && cur_ext_ok_ff && !rdy_sync)
                    nxt_state = ST_STROBE;  // R8 R9
                else if (!stretch_ff && phase_cnt_ff == cur_strobe_ff)
                    nxt_state = ST_HOLD;  // R3 R6 R19
            end
            ST_HOLD:
            begin
                if (phase_cnt_ff == cur_hold_ff)
                    nxt_state = ST_IDLE;  // R2 R5
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // phase counter restarts at one on each phase change and saturates while stretched
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
            phase_cnt_ff <= CNT_ONE;
        else if (nxt_state != state_ff)
            phase_cnt_ff <= CNT_ONE;
        else if (phase_cnt_ff != CNT_MAX)
            phase_cnt_ff <= phase_cnt_ff + CNT_ONE;
    end

    // =====================================================================
    // ready stretch: one look at the sample point, then wait for ready high
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            stretch_ff <= 1'b0;
            release_ff <= 1'b0;
        end
        else if (state_ff != ST_STROBE)
        begin
            stretch_ff <= 1'b0;
            release_ff <= 1'b0;
        end
        else
        begin
            if (samp_hit && cur_ext_ok_ff && !rdy_sync)
                stretch_ff <= 1'b1;  // R8 R9 R13
            // ready is assumed to stay high two cycles, so one sighting is enough
            if (stretch_ff && rdy_sync)
                release_ff <= 1'b1;  // R10 R11 R12
        end
    end

    // =====================================================================
    // pin drivers, all registered from the next state
    assign active = (nxt_state != ST_IDLE);

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            space_select_n_out        <= SEL_IDLE_N;
            byte_lane_enable_n_out    <= BE_IDLE_N;
            ext_word_address_out      <= '0;
            async_output_enable_n_out <= 1'b1;
            ext_data_bus_out          <= '0;
            ext_data_bus_oe_out       <= 1'b0;
        end
        else if (active)
        begin
            space_select_n_out        <= ~(4'h1 << sel_req.space);  // R14
            byte_lane_enable_n_out    <= ~sel_req.be;
            ext_word_address_out      <= sel_req.addr;
            async_output_enable_n_out <= sel_req.write;
            ext_data_bus_out          <= sel_req.wdata;
            ext_data_bus_oe_out       <= sel_req.write;  // R14
        end
        else
        begin
            // address and data keep their last value; only the enables go idle
            space_select_n_out        <= SEL_IDLE_N;
            byte_lane_enable_n_out    <= BE_IDLE_N;
            async_output_enable_n_out <= 1'b1;
            ext_data_bus_oe_out       <= 1'b0;
        end
    end

    // strobes follow the strobe phase exactly
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            async_read_strobe_n_out  <= 1'b1;
            async_write_strobe_n_out <= 1'b1;
        end
        else
        begin
            async_read_strobe_n_out  <= !((nxt_state == ST_STROBE) && !sel_req.write);  // R3
            async_write_strobe_n_out <= !((nxt_state == ST_STROBE) && sel_req.write);  // R6
        end
    end

    // =====================================================================
    // user side answer
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= '0;
        end
        else
        begin
            req_ready_out <= (nxt_state == ST_IDLE) && !accept;
            rsp_valid_out <= (state_ff == ST_HOLD) && (nxt_state == ST_IDLE);
            // capture on the last strobe cycle, while memory data is still driven
            if (state_ff == ST_STROBE && nxt_state == ST_HOLD && !cur_req_ff.write)
                rsp_rdata_out <= ext_data_bus_in;
        end
    end

    // =====================================================================
    // clock outputs
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
            half_rate_clock_out <= 1'b0;
        else
            half_rate_clock_out <= !half_rate_clock_out;  // R18
    end

    // the multiplier itself is analog; here only the selection is decoded and checked
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            pll_multiplier_out <= 4'h0;
            pll_mode_valid_out <= 1'b0;
        end
        else
        begin
            pll_multiplier_out <= pll_decode(pll_mode_sel_in);  // R17
            pll_mode_valid_out <= (pll_decode(pll_mode_sel_in) != 4'h0);
        end
    end

    // =====================================================================
    // checking helpers: phase lengths as seen on the pins
    logic [MON_W-1:0] pre_cnt_ff;
    logic [MON_W-1:0] post_cnt_ff;
    logic [MON_W-1:0] strb_cnt_ff;
    logic             post_phase_ff;
    logic             cs_idle;
    logic             strb_low;

    assign cs_idle  = &space_select_n_out;
    assign strb_low = !async_read_strobe_n_out || !async_write_strobe_n_out;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in || cs_idle)
        begin
            pre_cnt_ff    <= '0;
            post_cnt_ff   <= '0;
            post_phase_ff <= 1'b0;
        end
        else
        begin
            if (strb_low)
                post_phase_ff <= 1'b1;
            if (!strb_low && !post_phase_ff && pre_cnt_ff != MON_MAX)
                pre_cnt_ff <= pre_cnt_ff + 8'h01;
            if (!strb_low && post_phase_ff && post_cnt_ff != MON_MAX)
                post_cnt_ff <= post_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in || !strb_low)
            strb_cnt_ff <= '0;
        else if (strb_cnt_ff != MON_MAX)
            strb_cnt_ff <= strb_cnt_ff + 8'h01;
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    // =====================================================================
    // assertions
    a_read_setup_len: assert property ($fell(async_read_strobe_n_out) |-> pre_cnt_ff == {2'h0, cur_setup_ff}) // R1
        else $error("read setup length wrong");
    a_read_hold_len: assert property ($rose(cs_idle) && !cur_req_ff.write |-> post_cnt_ff == {2'h0, cur_hold_ff}) // R2
        else $error("read hold length wrong");
    a_read_strobe_len: assert property ($rose(async_read_strobe_n_out) && !stretch_ff
                                        |-> strb_cnt_ff == {2'h0, cur_strobe_ff}) // R3
        else $error("read strobe length wrong");
    a_write_setup_len: assert property ($fell(async_write_strobe_n_out)
                                        |-> pre_cnt_ff == {2'h0, cur_setup_ff} && ext_data_bus_oe_out) // R4
        else $error("write setup length wrong");
    a_write_hold_len: assert property ($rose(cs_idle) && cur_req_ff.write
                                       |-> post_cnt_ff == {2'h0, cur_hold_ff} && $past(ext_data_bus_oe_out)) // R5
        else $error("write hold length wrong");
    a_write_strobe_len: assert property ($rose(async_write_strobe_n_out) && !stretch_ff
                                         |-> strb_cnt_ff == {2'h0, cur_strobe_ff}) // R6
        else $error("write strobe length wrong");
    a_ready_sync_lat: assert property (##2 rdy_sync == $past(async_wait_release_in, 2)) // R7
        else $error("ready synchroniser latency wrong");
    a_ready_sample_hit: assert property (samp_hit && cur_ext_ok_ff && !rdy_sync
                                         |=> stretch_ff && strb_low) // R8 R9
        else $error("low ready at sample point did not stretch");
    a_release_delay: assert property (stretch_ff && rdy_sync && !release_ff |-> strb_low ##2 !strb_low) // R10 R11
        else $error("strobe release delay wrong");
    a_no_short_stretch: assert property (!cur_ext_ok_ff && state_ff == ST_STROBE |-> !stretch_ff) // R13 R19
        else $error("stretch with too short setup plus strobe");
    a_select_steady: assert property (!cs_idle && $past(!cs_idle) && !$rose(strb_low)
                                      |-> $stable(ext_word_address_out) && $stable(byte_lane_enable_n_out)) // R14
        else $error("select group moved inside an access");
    // the first edge out of reset still compares against the reset level, so it is skipped
    a_half_clock: assert property ($past(rst_b_in) |-> half_rate_clock_out != $past(half_rate_clock_out)) // R18
        else $error("half rate clock did not toggle");
    a_pll_valid: assert property (pll_mode_valid_out |-> pll_multiplier_out >= 4'h4 && pll_multiplier_out != 4'h5) // R17
        else $error("pll multiplier outside allowed set");

    c_read_plain: cover property ($rose(async_read_strobe_n_out) && !stretch_ff);
    c_read_stretch: cover property ($rose(async_read_strobe_n_out) && stretch_ff);
    c_write_stretch: cover property ($rose(async_write_strobe_n_out) && stretch_ff);
    c_back_to_back: cover property (rsp_valid_out ##[1:3] $fell(cs_idle));

endmodule

// [sim/amst_mem_model.sv]
// behavioural asynchronous memory that can stall its ready line
`timescale 1ns/1ps
module amst_mem_model
    import amst_pkg::*;
(
    input  wire logic              mclk_in,
    input  wire logic              cs_n_in,
    input  wire logic              oe_n_in,
    input  wire logic              we_n_in,
    input  wire logic              strobe_n_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [BE_W-1:0]   be_n_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic [7:0]        stall_in,
    output logic                   ready_out,
    output logic [DATA_W-1:0]      rdata_out
);
    logic [DATA_W-1:0] mem [16];
    logic [7:0]        low_cnt;
    initial
    begin
        foreach (mem[i]) mem[i] = 32'h0;
        low_cnt   = 8'h00;
        ready_out = 1'b1;
        rdata_out = 32'h0;
    end
    // =====================================================================
    // one process: writes, read drive and ready stall, just after each edge
    always @(posedge mclk_in)
    begin
        #1;
        if (!cs_n_in && !we_n_in)
            for (int b = 0; b < BE_W; b++)
                if (!be_n_in[b]) mem[addr_in[3:0]][8*b+:8] = wdata_in[8*b+:8];
        // a released bus shows the inverse, so a late capture cannot pass by luck
        rdata_out = (!cs_n_in && !oe_n_in) ? mem[addr_in[3:0]] : ~rdata_out;
        low_cnt   = cs_n_in ? 8'h00 : low_cnt + {7'h0, !strobe_n_in};
        ready_out = cs_n_in || (low_cnt >= stall_in);
    end
endmodule

// [sim/tb.sv]
// self-checking bench of the asynchronous memory strobe sequencer
`timescale 1ns/1ps
module tb;
    import amst_pkg::*;
    logic mclk_in, rst_b_in, req_valid_in, rdy, cs_n, strb;
    logic [2:0] pll_mode_sel_in;
    logic [7:0] stall;
    amst_cfg_t space_cfg_in;
    amst_req_s req_in;
    logic [DATA_W-1:0] mdata, bus;
    logic req_ready_out, rsp_valid_out, oe_n, re_n, we_n, d_oe, half_clk, pll_ok;
    logic [DATA_W-1:0] rsp_rdata_out, d_out;
    logic [SPACES-1:0] sel_n;
    logic [BE_W-1:0] be_n;
    logic [ADDR_W-1:0] addr;
    logic [3:0] pll_mul;
    int bad_count, n_checks;
    logic last_half;  // last sampled half-rate level, for the toggle comparison
    assign cs_n = &sel_n;
    assign strb = re_n & we_n;
    assign bus  = d_oe ? d_out : mdata;
    amst_async_seq u_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .space_cfg_in(space_cfg_in),
        .pll_mode_sel_in(pll_mode_sel_in), .req_valid_in(req_valid_in), .req_in(req_in),
        .async_wait_release_in(rdy), .ext_data_bus_in(bus), .req_ready_out(req_ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out), .space_select_n_out(sel_n),
        .byte_lane_enable_n_out(be_n), .ext_word_address_out(addr), .async_output_enable_n_out(oe_n),
        .async_read_strobe_n_out(re_n), .async_write_strobe_n_out(we_n), .ext_data_bus_out(d_out),
        .ext_data_bus_oe_out(d_oe), .half_rate_clock_out(half_clk), .pll_multiplier_out(pll_mul),
        .pll_mode_valid_out(pll_ok));
    amst_mem_model u_mem (.mclk_in(mclk_in), .cs_n_in(cs_n), .oe_n_in(oe_n), .we_n_in(we_n),
        .strobe_n_in(strb), .addr_in(addr), .be_n_in(be_n), .wdata_in(bus), .stall_in(stall),
        .ready_out(rdy), .rdata_out(mdata));
    // =====================================================================
    // 20 MHz clock
    initial
    begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one access; counts setup, strobe, hold samples; et of zero means a stretched strobe
    task automatic acc(input logic wr, input logic [1:0] sp, input logic [19:0] a, input logic [3:0] be,
                       input logic [31:0] wd, input logic [7:0] st, input int es, input int et, input int eh,
                       input logic [31:0] erd);
        int s, t, h, n, rr, sr;
        s = 0; t = 0; h = 0; n = 0; rr = 0; sr = 0;
        while (!req_ready_out && n < 50) begin @(posedge mclk_in); #1; n++; end
        if (n == 50) begin bad_count++; test_done(); end
        stall = st;
        req_in = '{wr, sp, a, be, wd};
        req_valid_in = 1'b1;
        @(posedge mclk_in); #1;
        req_valid_in = 1'b0;
        // look before waiting, so the setup cycle right after the taking edge is counted
        for (n = 1; n < 200 && !rsp_valid_out; n++)
        begin
            if (!cs_n && strb && t == 0) s++;
            if (!strb)
            begin
                if (t == 0) chk({sel_n, be_n, addr, oe_n}, {~(4'h1 << sp), ~be, a, wr});
                t++;
            end
            if (!cs_n && strb && t > 0) h++;
            if (rdy && rr == 0 && t > 0) rr = n;
            if (strb && sr == 0 && t > 0) sr = n;
            @(posedge mclk_in);
            #1;
        end
        if (n == 200) begin bad_count++; test_done(); end
        chk(s, es);
        chk(h, eh);
        if (et > 0) chk(t, et);
        else chk({t > st, (sr - rr) >= 3 && (sr - rr) <= 4}, 2'h3);
        if (!wr) chk(rsp_rdata_out, erd);
    endtask
    // =====================================================================
    // main sequence
    initial
    begin
        bad_count = 0; n_checks = 0;
        rst_b_in = 1'b0; req_valid_in = 1'b0; req_in = '0; stall = 8'h00; pll_mode_sel_in = 3'h0;
        // strobes sized wide enough for the memory's data setup
        space_cfg_in[0] = '{4'h1, 6'h02, 3'h1, 4'h1, 6'h02, 3'h1};
        space_cfg_in[1] = '{4'h3, 6'h02, 3'h2, 4'h2, 6'h03, 3'h2};
        space_cfg_in[2] = '{4'h2, 6'h04, 3'h1, 4'h1, 6'h05, 3'h2};
        space_cfg_in[3] = '{4'h4, 6'h06, 3'h3, 4'h2, 6'h01, 3'h3};
        repeat (6) @(posedge mclk_in);
        #1;
        chk({sel_n, re_n, we_n, oe_n, d_oe}, 8'hfe);
        rst_b_in = 1'b1;
        last_half = half_clk;
        // multiplier decode for every code, the unused one as well
        for (int c = 0; c < 8; c++)
        begin
            pll_mode_sel_in = c[2:0];
            @(posedge mclk_in); #1;
            chk({pll_ok, pll_mul}, c == 7 ? 5'h00 : {1'b1, c == 0 ? 4'h4 : 4'(c + 5)});
            chk(half_clk ^ last_half, 1'b1);
            last_half = half_clk;
        end
        acc(1, 1, 20'h5, 4'hf, 32'ha5a5c3c3, 0, 2, 3, 2, 0);
        acc(0, 1, 20'h5, 4'hf, 0, 0, 3, 2, 2, 32'ha5a5c3c3);
        acc(1, 0, 20'h6, 4'h5, 32'h11223344, 0, 1, 2, 1, 0);
        acc(0, 0, 20'h6, 4'hf, 0, 6, 1, 2, 1, 32'h00220044);
        acc(1, 3, 20'h7, 4'hf, 32'h0f0f1234, 6, 2, 1, 3, 0);
        acc(0, 3, 20'h7, 4'hf, 0, 0, 4, 6, 3, 32'h0f0f1234);
        acc(1, 2, 20'h8, 4'hf, 32'hdeadbeef, 8, 1, 0, 2, 0);
        acc(0, 2, 20'h8, 4'hf, 0, 8, 2, 0, 1, 32'hdeadbeef);
        test_done();
    end
endmodule
